// File: pkg/csd_pkg.sv
// Purpose: Shared constants and types of the clock select, divide and trim block
// Assumes: 8-bit register data, 9-bit register address
// Notes:   All oscillator sources arrive as one-cycle ticks on the system clock; the external pin arrives as a level
package csd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam int          ADDR_W          = 9;
    localparam int          DATA_W          = 8;

    localparam logic [8:0]  OFF_CPU_CLK     = 9'h030;
    localparam logic [8:0]  OFF_TMR_CLK     = 9'h031;
    localparam logic [8:0]  OFF_FAST_TRIM   = 9'h034;
    localparam logic [8:0]  OFF_SLOW_TRIM   = 9'h036;
    localparam logic [8:0]  OFF_RELOAD_LO   = 9'h040;
    localparam logic [8:0]  OFF_RELOAD_HI   = 9'h041;
    localparam logic [8:0]  OFF_COUNT_LO    = 9'h042;
    localparam logic [8:0]  OFF_COUNT_HI    = 9'h043;
    localparam logic [8:0]  OFF_STATUS      = 9'h044;
    localparam logic [8:0]  OFF_OSC_CTRL0   = 9'h1e0;

    localparam logic [7:0]  RST_CPU_CLK     = 8'h00;
    localparam logic [7:0]  RST_TMR_CLK     = 8'h8f;
    localparam logic [7:0]  RST_OSC_CTRL0   = 8'h00;
    localparam logic [7:0]  RST_SLOW_TRIM   = 8'h00;
    localparam logic [11:0] RST_RELOAD      = 12'h000;

    localparam logic [7:0]  MASK_CPU_CLK    = 8'h03;
    localparam logic [7:0]  MASK_OSC_CTRL0  = 8'h3f;
    localparam logic [7:0]  MASK_SLOW_TRIM  = 8'hbf;

    // Field positions
    localparam int          CPU_EXT_BIT     = 0;
    localparam int          CPU_SLOW_BIT    = 1;
    localparam int          CAP_DIV_LSB     = 6;
    localparam int          CAP_SEL_LSB     = 4;
    localparam int          INT_DIV_LSB     = 2;
    localparam int          INT_SEL_LSB     = 0;
    localparam int          SPEED_LSB       = 0;
    localparam int          SLOW_LP_BIT     = 7;
    localparam int          STAT_REC_BIT    = 0;

    // Timer source select codes
    localparam logic [1:0]  SEL_FAST        = 2'h0;
    localparam logic [1:0]  SEL_RSVD        = 2'h1;
    localparam logic [1:0]  SEL_SLOW        = 2'h2;
    localparam logic [1:0]  SEL_ALT         = 2'h3;

    // Processor speed codes
    localparam logic [2:0]  SPD_DIV8        = 3'h0;
    localparam logic [2:0]  SPD_DIV4        = 3'h1;
    localparam logic [2:0]  SPD_DIV2        = 3'h2;
    localparam logic [2:0]  SPD_DIV16       = 3'h4;
    localparam logic [2:0]  SPD_DIV32       = 3'h5;
    localparam logic [2:0]  SPD_DIV128      = 3'h6;

    // Terminal counts, ratio minus one
    localparam logic [7:0]  TC_DIV2         = 8'h01;
    localparam logic [7:0]  TC_DIV4         = 8'h03;
    localparam logic [7:0]  TC_DIV8         = 8'h07;
    localparam logic [7:0]  TC_DIV16        = 8'h0f;
    localparam logic [7:0]  TC_DIV32        = 8'h1f;
    localparam logic [7:0]  TC_DIV128       = 8'h7f;

    localparam logic [1:0]  RECOVER_TICKS   = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } csd_bus_req_type;

    typedef struct packed {
        logic fast;
        logic slow;
        logic xtal;
    } csd_src_type;

    typedef struct packed {
        logic       tick;
        logic [7:0] cnt;
    } csd_div_type;

    // One step of a tick divider
    function automatic csd_div_type csd_div_step(input logic [7:0] cnt,
                                                 input logic [7:0] term,
                                                 input logic       src);
        csd_div_type r;
        r.tick = 1'b0;
        r.cnt  = cnt;
        if (src) begin
            if (cnt >= term) begin
                r.tick = 1'b1;
                r.cnt  = 8'h00;
            end else begin
                r.cnt  = cnt + 8'h01;
            end
        end
        return r;
    endfunction : csd_div_step

    // Timer source mux, reserved code gives no ticks
    function automatic logic csd_pick(input logic [1:0] sel,
                                      input logic       fast,
                                      input logic       slow,
                                      input logic       alt);
        logic r;
        r = 1'b0;
        case (sel)
            SEL_FAST: r = fast;
            SEL_SLOW: r = slow;
            SEL_ALT:  r = alt;
            default:  r = 1'b0;
        endcase
        return r;
    endfunction : csd_pick

endpackage : csd_pkg

// File: verilog/csd_top.sv
// Purpose: Clock selection, division and oscillator trim with interval timer
// Assumes: Oscillators arrive as ticks; external pin is asynchronous
// Notes:   Divided clocks leave as one-cycle enables, never as gated clocks
`timescale 1ns/100ps
module csd_top #(
    parameter logic [7:0] FAST_TRIM_POR = 8'h10
) (
    input  wire logic                     clock,
    input  wire logic                     reset,
    input  wire logic                     clk_en,
    input  wire csd_pkg::csd_bus_req_type bus_req,
    output logic [7:0]                    bus_rdata,
    input  wire csd_pkg::csd_src_type     osc_tick,
    input  wire logic                     external_clock_pin,
    input  wire logic                     xtal_enable,
    input  wire logic                     sleep_req,
    output logic                          fast_osc_run,
    output logic                          fast_osc_recovered,
    output logic [7:0]                    fast_osc_trim,
    output logic [7:0]                    slow_osc_trim,
    output logic                          slow_osc_low_power,
    output logic                          processor_clock,
    output logic                          capture_timer_clock,
    output logic                          interval_timer_clock,
    output logic                          interval_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // External pin synchroniser and source qualification
    logic       pin_s1_ff, pin_s2_ff, pin_s3_ff;
    logic       nxt_pin_s1, nxt_pin_s2, nxt_pin_s3;
    logic       ext_tick, fast_tick, slow_tick;

    always_comb begin
        nxt_pin_s1 = external_clock_pin;
        nxt_pin_s2 = pin_s1_ff;
        nxt_pin_s3 = pin_s2_ff;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
            pin_s3_ff <= 1'b0;
        end else if (clk_en) begin
            pin_s1_ff <= nxt_pin_s1;
            pin_s2_ff <= nxt_pin_s2;
            pin_s3_ff <= nxt_pin_s3;
        end
    end

    assign ext_tick  = xtal_enable ? osc_tick.xtal : (pin_s2_ff & ~pin_s3_ff);
    assign slow_tick = osc_tick.slow;
    assign fast_tick = osc_tick.fast & fast_osc_run;

    ////////////////////////////////////////////////////////////////////////////
    // Sleep and fast oscillator recovery
    logic [1:0] rec_cnt_ff;
    logic       rec_ff;
    logic [1:0] nxt_rec_cnt;
    logic       nxt_rec;

    always_comb begin
        nxt_rec_cnt = rec_cnt_ff;
        nxt_rec     = rec_ff;
        if (sleep_req) begin
            nxt_rec_cnt = 2'h0;
            nxt_rec     = 1'b0;
        end else if (!rec_ff && slow_tick) begin
            nxt_rec_cnt = rec_cnt_ff + 2'h1;
            if (nxt_rec_cnt == csd_pkg::RECOVER_TICKS) begin
                nxt_rec = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rec_cnt_ff <= 2'h0;
            rec_ff     <= 1'b1;
        end else if (clk_en) begin
            rec_cnt_ff <= nxt_rec_cnt;
            rec_ff     <= nxt_rec;
        end
    end

    assign fast_osc_run       = rec_ff & ~sleep_req;
    assign fast_osc_recovered = rec_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0]  cpu_cfg_ff;
    logic [7:0]  tmr_cfg_ff;
    logic [7:0]  fast_trim_ff;
    logic [7:0]  slow_trim_ff;
    logic [7:0]  osc_ctrl0_ff;
    logic [11:0] reload_ff;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_cpu_cfg;
    logic [7:0]  nxt_tmr_cfg;
    logic [7:0]  nxt_fast_trim;
    logic [7:0]  nxt_slow_trim;
    logic [7:0]  nxt_osc_ctrl0;
    logic [11:0] nxt_reload;
    logic [7:0]  nxt_rdata;
    logic [11:0] count_ff;

    always_comb begin
        nxt_cpu_cfg   = cpu_cfg_ff;
        nxt_tmr_cfg   = tmr_cfg_ff;
        nxt_fast_trim = fast_trim_ff;
        nxt_slow_trim = slow_trim_ff;
        nxt_osc_ctrl0 = osc_ctrl0_ff;
        nxt_reload    = reload_ff;
        nxt_rdata     = 8'h00;
        if (bus_req.wr) begin
            case (bus_req.addr)
                csd_pkg::OFF_CPU_CLK:   nxt_cpu_cfg   = bus_req.wdata & csd_pkg::MASK_CPU_CLK;
                csd_pkg::OFF_TMR_CLK:   nxt_tmr_cfg   = bus_req.wdata;
                csd_pkg::OFF_FAST_TRIM: nxt_fast_trim = bus_req.wdata;
                csd_pkg::OFF_SLOW_TRIM: nxt_slow_trim = bus_req.wdata & csd_pkg::MASK_SLOW_TRIM;
                csd_pkg::OFF_OSC_CTRL0: nxt_osc_ctrl0 = bus_req.wdata & csd_pkg::MASK_OSC_CTRL0;
                csd_pkg::OFF_RELOAD_LO: nxt_reload[7:0]  = bus_req.wdata;
                csd_pkg::OFF_RELOAD_HI: nxt_reload[11:8] = bus_req.wdata[3:0];
                default: begin
                end
            endcase
        end
        if (sleep_req) begin
            // Sleep beats a write so the wake always starts internal
            nxt_cpu_cfg = csd_pkg::RST_CPU_CLK;
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                csd_pkg::OFF_CPU_CLK:   nxt_rdata = cpu_cfg_ff;
                csd_pkg::OFF_TMR_CLK:   nxt_rdata = tmr_cfg_ff;
                csd_pkg::OFF_FAST_TRIM: nxt_rdata = fast_trim_ff;
                csd_pkg::OFF_SLOW_TRIM: nxt_rdata = slow_trim_ff;
                csd_pkg::OFF_OSC_CTRL0: nxt_rdata = osc_ctrl0_ff;
                csd_pkg::OFF_RELOAD_LO: nxt_rdata = reload_ff[7:0];
                csd_pkg::OFF_RELOAD_HI: nxt_rdata = {4'h0, reload_ff[11:8]};
                csd_pkg::OFF_COUNT_LO:  nxt_rdata = count_ff[7:0];
                csd_pkg::OFF_COUNT_HI:  nxt_rdata = {4'h0, count_ff[11:8]};
                csd_pkg::OFF_STATUS:    nxt_rdata = {7'h00, rec_ff};
                default:                nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cpu_cfg_ff   <= csd_pkg::RST_CPU_CLK;
            tmr_cfg_ff   <= csd_pkg::RST_TMR_CLK;
            fast_trim_ff <= FAST_TRIM_POR;
            slow_trim_ff <= csd_pkg::RST_SLOW_TRIM;
            osc_ctrl0_ff <= csd_pkg::RST_OSC_CTRL0;
            reload_ff    <= csd_pkg::RST_RELOAD;
            rdata_ff     <= 8'h00;
        end else if (clk_en) begin
            cpu_cfg_ff   <= nxt_cpu_cfg;
            tmr_cfg_ff   <= nxt_tmr_cfg;
            fast_trim_ff <= nxt_fast_trim;
            slow_trim_ff <= nxt_slow_trim;
            osc_ctrl0_ff <= nxt_osc_ctrl0;
            reload_ff    <= nxt_reload;
            rdata_ff     <= nxt_rdata;
        end
    end

    assign bus_rdata          = rdata_ff;
    assign fast_osc_trim      = fast_trim_ff;
    assign slow_osc_trim      = slow_trim_ff;
    assign slow_osc_low_power = slow_trim_ff[csd_pkg::SLOW_LP_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Dividers; settings are taken at an output tick, or at once from a reserved select, so no runt appears
    logic [7:0]           cpu_cnt_ff, cap_cnt_ff, int_cnt_ff;
    logic [4:0]           cpu_act_ff;
    logic [3:0]           cap_act_ff, int_act_ff;
    logic                 cpu_tick_ff, cap_tick_ff, int_tick_ff;
    logic [7:0]           nxt_cpu_cnt, nxt_cap_cnt, nxt_int_cnt;
    logic [4:0]           nxt_cpu_act;
    logic [3:0]           nxt_cap_act, nxt_int_act;
    logic                 nxt_cpu_tick, nxt_cap_tick, nxt_int_tick;
    logic                 cpu_src, cap_src, int_src;
    logic [7:0]           cpu_term, cap_term, int_term;
    csd_pkg::csd_div_type cpu_step, cap_step, int_step;

    always_comb begin
        // Processor: slow bit, ext bit, speed field
        if (cpu_act_ff[4]) begin
            cpu_src = slow_tick;
        end else if (cpu_act_ff[3]) begin
            cpu_src = ext_tick;
        end else begin
            cpu_src = fast_tick;
        end
        case (cpu_act_ff[2:0])
            csd_pkg::SPD_DIV8:   cpu_term = csd_pkg::TC_DIV8;
            csd_pkg::SPD_DIV4:   cpu_term = csd_pkg::TC_DIV4;
            csd_pkg::SPD_DIV2:   cpu_term = csd_pkg::TC_DIV2;
            csd_pkg::SPD_DIV16:  cpu_term = csd_pkg::TC_DIV16;
            csd_pkg::SPD_DIV32:  cpu_term = csd_pkg::TC_DIV32;
            csd_pkg::SPD_DIV128: cpu_term = csd_pkg::TC_DIV128;
            default:             cpu_term = csd_pkg::TC_DIV8;
        endcase
        // Capture: 2, 4, 6, 8
        cap_src  = csd_pkg::csd_pick(cap_act_ff[1:0], fast_tick, slow_tick, ext_tick);
        cap_term = {5'h00, cap_act_ff[3:2], 1'b1};
        cpu_step = csd_pkg::csd_div_step(cpu_cnt_ff, cpu_term, cpu_src);
        cap_step = csd_pkg::csd_div_step(cap_cnt_ff, cap_term, cap_src);
        // Interval: 1..4, may chain off the capture tick
        int_src  = csd_pkg::csd_pick(int_act_ff[1:0], fast_tick, slow_tick, cap_step.tick);
        int_term = {6'h00, int_act_ff[3:2]};
        int_step = csd_pkg::csd_div_step(int_cnt_ff, int_term, int_src);

        nxt_cpu_cnt  = cpu_step.cnt;
        nxt_cap_cnt  = cap_step.cnt;
        nxt_int_cnt  = int_step.cnt;
        nxt_cpu_tick = cpu_step.tick;
        nxt_cap_tick = cap_step.tick;
        nxt_int_tick = int_step.tick;
        nxt_cpu_act  = cpu_act_ff;
        nxt_cap_act  = cap_act_ff;
        nxt_int_act  = int_act_ff;
        // Each path takes its own settings independently
        if (cpu_step.tick) begin
            nxt_cpu_act = {cpu_cfg_ff[csd_pkg::CPU_SLOW_BIT], cpu_cfg_ff[csd_pkg::CPU_EXT_BIT],
                           osc_ctrl0_ff[csd_pkg::SPEED_LSB +: 3]};
        end
        // A stopped reserved path would never tick, so it may switch at once
        if (cap_step.tick || cap_act_ff[1:0] == csd_pkg::SEL_RSVD) begin
            nxt_cap_act = tmr_cfg_ff[csd_pkg::CAP_SEL_LSB +: 4]; // Divider sits above select
            if (!cap_step.tick) begin
                nxt_cap_cnt = 8'h00;
            end
        end
        if (int_step.tick || int_act_ff[1:0] == csd_pkg::SEL_RSVD) begin
            nxt_int_act = tmr_cfg_ff[csd_pkg::INT_SEL_LSB +: 4]; // Divider sits above select
            if (!int_step.tick) begin
                nxt_int_cnt = 8'h00;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cpu_cnt_ff  <= 8'h00;
            cap_cnt_ff  <= 8'h00;
            int_cnt_ff  <= 8'h00;
            cpu_act_ff  <= {csd_pkg::RST_CPU_CLK[1:0], csd_pkg::RST_OSC_CTRL0[2:0]};
            cap_act_ff  <= csd_pkg::RST_TMR_CLK[7:4];
            int_act_ff  <= csd_pkg::RST_TMR_CLK[3:0];
            cpu_tick_ff <= 1'b0;
            cap_tick_ff <= 1'b0;
            int_tick_ff <= 1'b0;
        end else if (clk_en) begin
            cpu_cnt_ff  <= nxt_cpu_cnt;
            cap_cnt_ff  <= nxt_cap_cnt;
            int_cnt_ff  <= nxt_int_cnt;
            cpu_act_ff  <= nxt_cpu_act;
            cap_act_ff  <= nxt_cap_act;
            int_act_ff  <= nxt_int_act;
            cpu_tick_ff <= nxt_cpu_tick;
            cap_tick_ff <= nxt_cap_tick;
            int_tick_ff <= nxt_int_tick;
        end
    end

    assign processor_clock      = cpu_tick_ff;
    assign capture_timer_clock  = cap_tick_ff;
    assign interval_timer_clock = int_tick_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Interval down counter; a zero count spends the next tick reloading
    logic [11:0] nxt_count;
    logic        irq_ff;
    logic        nxt_irq;

    always_comb begin
        nxt_count = count_ff;
        nxt_irq   = 1'b0;
        if (int_tick_ff) begin
            if (count_ff == 12'h000) begin
                nxt_count = reload_ff;
                nxt_irq   = 1'b1;
            end else begin
                nxt_count = count_ff - 12'h001;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_ff <= 12'h000;
            irq_ff   <= 1'b0;
        end else if (clk_en) begin
            count_ff <= nxt_count;
            irq_ff   <= nxt_irq;
        end
    end

    assign interval_irq = irq_ff;

endmodule : csd_top

// File: sim/csd_top_chk.sv
// Purpose: Port-level assertions for the clock select, divide and trim block
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Divider ratios are measured by the bench; here only timing relations
`timescale 1ns/100ps
module csd_top_chk #(
    parameter logic [7:0] FAST_TRIM_POR = 8'h10
) (
    input wire logic                     clock,
    input wire logic                     reset,
    input wire logic                     clk_en,
    input wire csd_pkg::csd_bus_req_type bus_req,
    input wire logic [7:0]               bus_rdata,
    input wire csd_pkg::csd_src_type     osc_tick,
    input wire logic                     sleep_req,
    input wire logic                     fast_osc_run,
    input wire logic                     fast_osc_recovered,
    input wire logic [7:0]               fast_osc_trim,
    input wire logic [7:0]               slow_osc_trim,
    input wire logic                     slow_osc_low_power,
    input wire logic                     processor_clock,
    input wire logic                     capture_timer_clock,
    input wire logic                     interval_timer_clock,
    input wire logic                     interval_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////
    por_trim_a: assert property ($fell(reset) |-> fast_osc_trim == FAST_TRIM_POR)
        else $error("fast trim not at power-on value after reset");
    low_power_a: assert property (slow_osc_low_power == slow_osc_trim[7])
        else $error("slow oscillator mode differs from trim bit 7");
    run_gate_a: assert property (fast_osc_run == (fast_osc_recovered && !sleep_req))
        else $error("fast oscillator run not gated by sleep and recovery");
    sleep_stop_a: assert property (sleep_req && clk_en |=> !fast_osc_recovered)
        else $error("fast oscillator still recovered during sleep");
    recover_tick_a: assert property ($rose(fast_osc_recovered) |->
        $past(osc_tick.slow) && !$past(sleep_req))
        else $error("recovery not ended by a slow tick outside sleep");
    irq_cause_a: assert property (interval_irq && $past(clk_en) |->
        $past(interval_timer_clock))
        else $error("interrupt without an interval tick");
    // Minimum ratio is two, so back-to-back pulses mean a runt
    cpu_no_runt_a: assert property (processor_clock && clk_en |=> !processor_clock)
        else $error("processor clock pulses in two adjacent cycles");
    cap_no_runt_a: assert property (capture_timer_clock && clk_en |=>
        !capture_timer_clock)
        else $error("capture clock pulses in two adjacent cycles");
    rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
        else $error("read data outside the cycle after a read");

endmodule : csd_top_chk

bind csd_top csd_top_chk #(.FAST_TRIM_POR(FAST_TRIM_POR)) u_csd_chk (
    .clock(clock), .reset(reset), .clk_en(clk_en), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .osc_tick(osc_tick), .sleep_req(sleep_req),
    .fast_osc_run(fast_osc_run), .fast_osc_recovered(fast_osc_recovered),
    .fast_osc_trim(fast_osc_trim), .slow_osc_trim(slow_osc_trim),
    .slow_osc_low_power(slow_osc_low_power), .processor_clock(processor_clock),
    .capture_timer_clock(capture_timer_clock),
    .interval_timer_clock(interval_timer_clock), .interval_irq(interval_irq)
);

// File: sim/csd_top_tb_top.sv
// Purpose: Self-checking bench for the clock select, divide and trim block
// Assumes: Fast tick every 5 cycles, slow every 40, crystal every 3
// Notes:   Divider ratios are judged by the gap between output pulses
`timescale 1ns/100ps
module csd_top_tb_top;
    localparam logic [7:0] POR_TRIM = 8'h5a; // Arbitrary power-on trim
    logic                     clock, reset, clk_en, ext_pin, xtal_en, sleep_req;
    csd_pkg::csd_bus_req_type req;
    csd_pkg::csd_src_type     osc;
    logic [7:0]               rdata, fast_trim, slow_trim, r;
    logic                     run, recovered, low_power, cpu_clk, cap_clk, int_clk, irq;
    logic                     rd_d;
    logic [3:0]               pv;
    int                       tcnt, cycles, failures, cmp_count, n, t;
    int                       spd_ratio[8] = '{8, 4, 2, 8, 16, 32, 128, 8};
    logic [7:0]               exp_q[$];

    csd_top #(.FAST_TRIM_POR(POR_TRIM)) DUT (
        .clock(clock), .reset(reset), .clk_en(clk_en), .bus_req(req), .bus_rdata(rdata),
        .osc_tick(osc), .external_clock_pin(ext_pin), .xtal_enable(xtal_en),
        .sleep_req(sleep_req), .fast_osc_run(run), .fast_osc_recovered(recovered),
        .fast_osc_trim(fast_trim), .slow_osc_trim(slow_trim),
        .slow_osc_low_power(low_power), .processor_clock(cpu_clk),
        .capture_timer_clock(cap_clk), .interval_timer_clock(int_clk),
        .interval_irq(irq)
    );
    assign pv = {irq, int_clk, cap_clk, cpu_clk};

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Stopped fast oscillator gives no ticks, as in silicon
    always @(posedge clock) begin
        tcnt     <= tcnt + 1;
        osc.fast <= run && (tcnt % 5 == 0);
        osc.slow <= (tcnt % 40 == 7);
        osc.xtal <= (tcnt % 3 == 1);
        ext_pin  <= (tcnt % 14) < 7;
        rd_d     <= req.rd && clk_en;
        cycles   <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            print_verdict();
        end
    end

    always @(negedge clock) if (rd_d) check(rdata, exp_q.pop_front(), "rdata");

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] e, input string what);
        cmp_count++;
        if (seen !== e) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", what, e, seen);
        end
    endtask : check

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge clock);
        exp_q.push_back(e);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
    endtask : rd

    task automatic wait_p(input int k, output int c);
        c = 0;
        do begin
            @(negedge clock);
            c++;
        end while (pv[k] !== 1'b1 && c < 3000);
    endtask : wait_p

    // First pulses may still run at the old ratio
    task automatic gap(input int k, input int e);
        int c;
        if (e == 0) begin
            repeat (400) @(negedge clock);
        end else begin
            repeat (3) wait_p(k, c);
        end
        wait_p(k, c);
        check((c >= 3000) ? 0 : c, e, "pulse gap");
    endtask : gap

    task automatic print_verdict;
        if (failures == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {reset, clk_en, ext_pin, xtal_en, sleep_req, rd_d} = 6'b110000;
        {tcnt, cycles, failures, cmp_count} = '0;
        req = '0;
        osc = '0;
        void'($urandom(98));
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        rd(csd_pkg::OFF_CPU_CLK, 8'h00);
        rd(csd_pkg::OFF_TMR_CLK, 8'h8f);
        rd(csd_pkg::OFF_OSC_CTRL0, 8'h00);
        rd(csd_pkg::OFF_FAST_TRIM, POR_TRIM);
        check(fast_trim, POR_TRIM, "fast trim");
        rd(csd_pkg::OFF_RELOAD_LO, 8'h00);
        rd(9'h100, 8'h00);
        r = 8'($urandom);
        wr(csd_pkg::OFF_FAST_TRIM, r);
        rd(csd_pkg::OFF_FAST_TRIM, r);
        check(fast_trim, r, "fast trim");
        wr(csd_pkg::OFF_SLOW_TRIM, r);
        rd(csd_pkg::OFF_SLOW_TRIM, r & csd_pkg::MASK_SLOW_TRIM);
        check(low_power, r[7], "low power");
        check(slow_trim, r & csd_pkg::MASK_SLOW_TRIM, "slow trim");
        wr(csd_pkg::OFF_CPU_CLK, r);
        rd(csd_pkg::OFF_CPU_CLK, r & csd_pkg::MASK_CPU_CLK);
        wr(csd_pkg::OFF_CPU_CLK, 8'h00);
        wr(csd_pkg::OFF_TMR_CLK, ~r);
        rd(csd_pkg::OFF_TMR_CLK, ~r);
        repeat (3) @(posedge clock);
        clk_en <= 1'b0;
        wr(csd_pkg::OFF_FAST_TRIM, ~r);
        clk_en <= 1'b1;
        rd(csd_pkg::OFF_FAST_TRIM, r);
        for (int s = 0; s < 8; s++) begin
            wr(csd_pkg::OFF_OSC_CTRL0, {2'h0, 3'($urandom), 3'(s)});
            gap(0, 5 * spd_ratio[s]);
        end
        wr(csd_pkg::OFF_OSC_CTRL0, 8'h02);
        xtal_en <= 1'b1;
        wr(csd_pkg::OFF_CPU_CLK, 8'h01);
        gap(0, 6);
        xtal_en <= 1'b0;
        gap(0, 28);
        wr(csd_pkg::OFF_CPU_CLK, 8'h02);
        gap(0, 80);
        wr(csd_pkg::OFF_CPU_CLK, 8'h00);
        for (int d = 0; d < 4; d++) begin
            wr(csd_pkg::OFF_TMR_CLK, {2'(d), 6'h00});
            gap(1, 10 * (d + 1));
        end
        wr(csd_pkg::OFF_TMR_CLK, 8'h20);
        gap(1, 80);
        wr(csd_pkg::OFF_TMR_CLK, 8'h30);
        gap(1, 28);
        wr(csd_pkg::OFF_TMR_CLK, 8'h10);
        gap(1, 0);
        gap(0, 10);
        for (int d = 0; d < 4; d++) begin
            wr(csd_pkg::OFF_TMR_CLK, {4'h0, 2'(d), 2'h0});
            gap(2, 5 * (d + 1));
        end
        wr(csd_pkg::OFF_TMR_CLK, 8'h02);
        gap(2, 40);
        wr(csd_pkg::OFF_TMR_CLK, 8'h07);
        gap(2, 20);
        wr(csd_pkg::OFF_TMR_CLK, 8'h01);
        gap(2, 0);
        wr(csd_pkg::OFF_TMR_CLK, 8'h00);
        n = $urandom_range(60, 1);
        wr(csd_pkg::OFF_RELOAD_LO, 8'(n));
        wr(csd_pkg::OFF_RELOAD_HI, 8'h00);
        gap(3, 5 * (n + 1));
        // Slow interval ticks leave 40 cycles after a reload to read the count
        wr(csd_pkg::OFF_TMR_CLK, 8'h02);
        repeat (2) wait_p(3, t);
        rd(csd_pkg::OFF_COUNT_LO, 8'(n));
        rd(csd_pkg::OFF_COUNT_LO, 8'(n));
        rd(csd_pkg::OFF_COUNT_HI, 8'h00);
        wr(csd_pkg::OFF_RELOAD_HI, r);
        rd(csd_pkg::OFF_RELOAD_HI, r & 8'h0f);
        sleep_req <= 1'b1;
        repeat (4) @(posedge clock);
        check(recovered, 1'b0, "recovered");
        check(run, 1'b0, "osc run");
        wr(csd_pkg::OFF_CPU_CLK, 8'h01);
        rd(csd_pkg::OFF_CPU_CLK, 8'h00);
        sleep_req <= 1'b0;
        {n, t} = '0;
        while (recovered !== 1'b1 && n < 1000) begin
            @(negedge clock);
            n++;
            if (osc.slow === 1'b1 && recovered !== 1'b1) t++;
        end
        check(t, 3, "recovery ticks");
        gap(0, 10);
        print_verdict();
    end

endmodule : csd_top_tb_top
